// ---- src/ats_pkg.sv ----
// constants, layouts and carriers of the acquisition timing sequencer
// assumes a 40 MHz core clock and a 32-bit classic wishbone master
package ats_pkg;
  // ==========================================
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int PULSE_MIN_NS = 50;
  localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_DLY_NS = 50;
  localparam int SCLK_DLY_CYC = (SCLK_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_WID_NS = 400;
  localparam int SCLK_WID_CYC = (SCLK_WID_NS + CLK_NS - 1) / CLK_NS;
  localparam int TB_FAST_HZ = 20_000_000;
  localparam int TB_SLOW_HZ = 100_000;
  localparam int TB_FAST_DIV = CLK_HZ / TB_FAST_HZ;
  localparam int TB_SLOW_DIV = CLK_HZ / TB_SLOW_HZ;
  localparam int STRB_SLOW_NS = 10_000;
  localparam int STRB_FAST_NS = 1_200;
  localparam int STRB_SLOW_HALF = STRB_SLOW_NS / (2 * CLK_NS);
  localparam int STRB_FAST_HALF = STRB_FAST_NS / (2 * CLK_NS);
  localparam int STRB_PULSES = 8;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SRC = 8'h04;
  localparam logic [7:0] ADR_CMD = 8'h08;
  localparam logic [7:0] ADR_PRE = 8'h0c;
  localparam logic [7:0] ADR_POST = 8'h10;
  localparam logic [7:0] ADR_SCANIV = 8'h14;
  localparam logic [7:0] ADR_SAMPIV = 8'h18;
  localparam logic [7:0] ADR_CONVN = 8'h1c;
  localparam logic [7:0] ADR_PINOE = 8'h20;
  localparam logic [7:0] ADR_STAT = 8'h24;
  localparam logic [7:0] ADR_CNT = 8'h28;
  // command bits, pin assignment
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_STRB = 2;
  localparam int PIN_T1 = 0;
  localparam int PIN_T2 = 1;
  localparam int PIN_CONV = 2;
  localparam int PIN_SCAN = 7;
  // ==========================================
  // types and reset values
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PRE = 2'b01, ST_WAIT2 = 2'b11, ST_POST = 2'b10
  } ats_phase_e;
  typedef struct packed {
    logic strbFast; logic strbLevel; logic strbHw; logic sclkPol;
    logic sclkEn; logic scanOutLvl; logic swGate; logic gateEn;
    logic gateLvlMode; logic slowTb; logic siExt; logic convExt;
    logic scanExt; logic preMode;
  } ats_ctrl_s;
  typedef struct packed {
    logic siPol; logic gatePol; logic convPol; logic scanPol;
    logic t2Pol; logic t1Pol;
    logic [3:0] siSel; logic [3:0] gateSel; logic [3:0] convSel;
    logic [3:0] scanSel; logic [3:0] t2Sel; logic [3:0] t1Sel;
  } ats_src_s;
  typedef struct packed {
    logic gateShut; logic scanBusy; ats_phase_e phase;
  } ats_stat_s;
  localparam ats_ctrl_s CTRL_RST = '0;
  localparam ats_src_s SRC_RST = '0;
  localparam int COUNT_RST = 1;
  localparam int PINOE_RST = 0;
endpackage

// ---- src/ats_sequencer.sv ----
// acquisition timing sequencer: triggers, scan and conversion timing,
// function pin routing, scan clock and strobe outputs
// assumes asynchronous pin inputs and a classic wishbone master
`timescale 1ns/10ps
module ats_sequencer #(
  parameter int NPINS = 10,
  parameter int CW = 24
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NPINS-1:0] functionPinIn,
  output logic [NPINS-1:0] functionPinOut,
  output logic [NPINS-1:0] functionPinOe,
  output logic scanClockOut,
  output logic externalStrobeOutN
);
  // ==========================================
  // helpers
  localparam logic [2:0] PULSE_LD = 3'(ats_pkg::PULSE_CYC);
  localparam logic [4:0] SCLK_WID = 5'(ats_pkg::SCLK_WID_CYC);
  localparam logic [4:0] SCLK_LD = 5'(ats_pkg::SCLK_DLY_CYC + ats_pkg::SCLK_WID_CYC);
  localparam logic [8:0] TB_FAST = 9'(ats_pkg::TB_FAST_DIV);
  localparam logic [8:0] TB_SLOW = 9'(ats_pkg::TB_SLOW_DIV);
  localparam logic [8:0] STRB_SLOW = 9'(ats_pkg::STRB_SLOW_HALF);
  localparam logic [8:0] STRB_FAST = 9'(ats_pkg::STRB_FAST_HALF);
  localparam logic [4:0] STRB_HALVES = 5'(2 * ats_pkg::STRB_PULSES);
  localparam logic [CW-1:0] CNT_RST = CW'(ats_pkg::COUNT_RST);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  function automatic logic selLvl(input logic [NPINS-1:0] v, input logic [3:0] sel,
                                  input logic pol);
    logic r;
    r = 1'b0;
    if (int'(sel) < NPINS) begin
      r = v[sel] ^ pol;
    end
    return r;
  endfunction

  function automatic logic selEdge(input logic [NPINS-1:0] cur, input logic [NPINS-1:0] prv,
                                   input logic [3:0] sel, input logic pol);
    return selLvl(cur, sel, pol) & ~selLvl(prv, sel, pol);
  endfunction

  function automatic logic [31:0] wbMerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i+:8] = nw[8*i+:8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] tmrNext(input logic ld, input logic [2:0] t);
    logic [2:0] r;
    r = 3'h0;
    if (ld) begin
      r = PULSE_LD;
    end else if (t != 3'h0) begin
      r = t - 3'h1;
    end
    return r;
  endfunction

  // ==========================================
  // registers
  ats_pkg::ats_ctrl_s ctrl_ff;
  ats_pkg::ats_src_s src_ff;
  logic [CW-1:0] preN_ff;
  logic [CW-1:0] postN_ff;
  logic [CW-1:0] scanIv_ff;
  logic [CW-1:0] sampIv_ff;
  logic [CW-1:0] convN_ff;
  logic [NPINS-1:0] pinOeReg_ff;
  logic wbAck_ff;
  logic [31:0] wbDat_ff;
  logic [31:0] nxt_rdData;
  logic wrEn;
  logic cmdStart;
  logic cmdStop;
  logic cmdStrb;

  // ==========================================
  // sequencing state
  logic [NPINS-1:0] pinS1_ff;
  logic [NPINS-1:0] pinS2_ff;
  logic [NPINS-1:0] pinS3_ff;
  ats_pkg::ats_phase_e phase_ff;
  logic [CW-1:0] scanCnt_ff;
  logic [CW-1:0] siCnt_ff;
  logic [CW-1:0] sampCnt_ff;
  logic [CW-1:0] convLeft_ff;
  logic [8:0] tbCnt_ff;
  logic tbTick_ff;
  logic siReq_ff;
  logic scanBusy_ff;
  logic gateShut_ff;
  logic [2:0] t1Tmr_ff;
  logic [2:0] t2Tmr_ff;
  logic [2:0] scanTmr_ff;
  logic [2:0] convTmr_ff;
  logic [4:0] sclkTmr_ff;
  logic [4:0] strbLeft_ff;
  logic [8:0] strbCnt_ff;
  logic [NPINS-1:0] pinOut_ff;
  logic [NPINS-1:0] pinOe_ff;
  logic sclkOut_ff;
  logic strbOut_ff;

  logic idle;
  logic t1Go;
  logic t2Go;
  logic siTick;
  logic scanReq;
  logic gateBlock;
  logic scanGo;
  logic sampZero;
  logic convGo;
  logic lastConv;
  logic [NPINS-1:0] nxt_pinOut;

  assign wb_ack_o = wbAck_ff;
  assign wb_dat_o = wbDat_ff;
  assign functionPinOut = pinOut_ff;
  assign functionPinOe = pinOe_ff;
  assign scanClockOut = sclkOut_ff;
  assign externalStrobeOutN = strbOut_ff;

  // ==========================================
  // wishbone slave, one wait state
  assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & ~wbAck_ff;
  assign cmdStart = wrEn && wb_adr_i == ats_pkg::ADR_CMD && wb_sel_i[0]
                    && wb_dat_i[ats_pkg::CMD_START];
  assign cmdStop = wrEn && wb_adr_i == ats_pkg::ADR_CMD && wb_sel_i[0]
                   && wb_dat_i[ats_pkg::CMD_STOP];
  assign cmdStrb = wrEn && wb_adr_i == ats_pkg::ADR_CMD && wb_sel_i[0]
                   && wb_dat_i[ats_pkg::CMD_STRB];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wbAck_ff <= 1'b0;
      wbDat_ff <= 32'h0;
    end else begin
      wbAck_ff <= wb_cyc_i & wb_stb_i & ~wbAck_ff;
      wbDat_ff <= nxt_rdData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= ats_pkg::CTRL_RST;
      src_ff <= ats_pkg::SRC_RST;
      preN_ff <= CNT_RST;
      postN_ff <= CNT_RST;
      scanIv_ff <= CNT_RST;
      sampIv_ff <= CNT_RST;
      convN_ff <= CNT_RST;
      pinOeReg_ff <= NPINS'(ats_pkg::PINOE_RST);
    end else if (wrEn) begin
      case (wb_adr_i)
        ats_pkg::ADR_CTRL: ctrl_ff <= $bits(ctrl_ff)'(wbMerge(32'(ctrl_ff), wb_dat_i, wb_sel_i));
        ats_pkg::ADR_SRC: src_ff <= $bits(src_ff)'(wbMerge(32'(src_ff), wb_dat_i, wb_sel_i));
        ats_pkg::ADR_PRE: preN_ff <= CW'(wbMerge(32'(preN_ff), wb_dat_i, wb_sel_i));
        ats_pkg::ADR_POST: postN_ff <= CW'(wbMerge(32'(postN_ff), wb_dat_i, wb_sel_i));
        ats_pkg::ADR_SCANIV: scanIv_ff <= CW'(wbMerge(32'(scanIv_ff), wb_dat_i, wb_sel_i));
        ats_pkg::ADR_SAMPIV: sampIv_ff <= CW'(wbMerge(32'(sampIv_ff), wb_dat_i, wb_sel_i));
        ats_pkg::ADR_CONVN: convN_ff <= CW'(wbMerge(32'(convN_ff), wb_dat_i, wb_sel_i));
        ats_pkg::ADR_PINOE: pinOeReg_ff <= NPINS'(wbMerge(32'(pinOeReg_ff), wb_dat_i, wb_sel_i));
        default: begin
        end
      endcase
    end
  end

  // unmapped and command addresses read as zero
  always_comb begin
    case (wb_adr_i)
      ats_pkg::ADR_CTRL: nxt_rdData = 32'(ctrl_ff);
      ats_pkg::ADR_SRC: nxt_rdData = 32'(src_ff);
      ats_pkg::ADR_PRE: nxt_rdData = 32'(preN_ff);
      ats_pkg::ADR_POST: nxt_rdData = 32'(postN_ff);
      ats_pkg::ADR_SCANIV: nxt_rdData = 32'(scanIv_ff);
      ats_pkg::ADR_SAMPIV: nxt_rdData = 32'(sampIv_ff);
      ats_pkg::ADR_CONVN: nxt_rdData = 32'(convN_ff);
      ats_pkg::ADR_PINOE: nxt_rdData = 32'(pinOeReg_ff);
      ats_pkg::ADR_STAT: nxt_rdData = 32'(ats_pkg::ats_stat_s'({gateShut_ff, scanBusy_ff, phase_ff}));
      ats_pkg::ADR_CNT: nxt_rdData = 32'(scanCnt_ff);
      default: nxt_rdData = 32'h0;
    endcase
  end

  // ==========================================
  // pin synchroniser; stage one feeds stage two only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinS1_ff <= '0;
      pinS2_ff <= '0;
      pinS3_ff <= '0;
    end else begin
      pinS1_ff <= functionPinIn;
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
    end
  end

  // ==========================================
  // events
  assign idle = phase_ff == ats_pkg::ST_IDLE;
  assign t1Go = idle & (cmdStart
                | selEdge(pinS2_ff, pinS3_ff, src_ff.t1Sel, src_ff.t1Pol));
  assign t2Go = phase_ff == ats_pkg::ST_WAIT2
                & selEdge(pinS2_ff, pinS3_ff, src_ff.t2Sel, src_ff.t2Pol);
  // external clock sampled at 40 MHz: phases under 25 ns may be missed
  assign siTick = ctrl_ff.siExt ? selEdge(pinS2_ff, pinS3_ff, src_ff.siSel, src_ff.siPol)
                  : tbTick_ff;
  assign scanReq = ctrl_ff.scanExt
                   ? selEdge(pinS2_ff, pinS3_ff, src_ff.scanSel, src_ff.scanPol)
                   : siReq_ff;
  assign gateBlock = ctrl_ff.swGate | (ctrl_ff.gateEn & (ctrl_ff.gateLvlMode
                     ? selLvl(pinS2_ff, src_ff.gateSel, src_ff.gatePol) : gateShut_ff));
  // gate only sampled here, so a running scan is never cut off
  assign scanGo = !idle && !scanBusy_ff && scanReq && !gateBlock && !cmdStop
                  && !(phase_ff == ats_pkg::ST_POST && scanCnt_ff == '0);
  assign sampZero = !ctrl_ff.convExt && sampCnt_ff <= CNT_ONE;
  assign convGo = scanBusy_ff && !idle && (ctrl_ff.convExt
                  ? selEdge(pinS2_ff, pinS3_ff, src_ff.convSel, src_ff.convPol)
                  : sampZero);
  assign lastConv = convLeft_ff <= CNT_ONE;

  // ==========================================
  // acquisition phase and scan counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_ff <= ats_pkg::ST_IDLE;
      scanCnt_ff <= '0;
    end else if (cmdStop) begin
      phase_ff <= ats_pkg::ST_IDLE;
    end else begin
      case (phase_ff)
        ats_pkg::ST_IDLE: begin
          if (t1Go && ctrl_ff.preMode && preN_ff != '0) begin
            phase_ff <= ats_pkg::ST_PRE;
            scanCnt_ff <= preN_ff;
          end else if (t1Go && ctrl_ff.preMode) begin
            phase_ff <= ats_pkg::ST_WAIT2;
            scanCnt_ff <= postN_ff;
          end else if (t1Go) begin
            phase_ff <= ats_pkg::ST_POST;
            scanCnt_ff <= postN_ff;
          end
        end
        ats_pkg::ST_PRE: begin
          if (scanGo && scanCnt_ff <= CNT_ONE) begin
            phase_ff <= ats_pkg::ST_WAIT2;
            scanCnt_ff <= postN_ff;
          end else if (scanGo) begin
            scanCnt_ff <= scanCnt_ff - CNT_ONE;
          end
        end
        ats_pkg::ST_WAIT2: begin
          if (t2Go) begin
            phase_ff <= ats_pkg::ST_POST;
          end
        end
        ats_pkg::ST_POST: begin
          if (scanGo) begin
            scanCnt_ff <= scanCnt_ff - CNT_ONE;
          end else if (scanCnt_ff == '0 && !scanBusy_ff) begin
            phase_ff <= ats_pkg::ST_IDLE;
          end
        end
        default: phase_ff <= ats_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // timebase and scan interval counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tbCnt_ff <= 9'h1;
      tbTick_ff <= 1'b0;
    end else if (tbCnt_ff <= 9'h1) begin
      tbCnt_ff <= ctrl_ff.slowTb ? TB_SLOW : TB_FAST;
      tbTick_ff <= 1'b1;
    end else begin
      tbCnt_ff <= tbCnt_ff - 9'h1;
      tbTick_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      siCnt_ff <= '0;
      siReq_ff <= 1'b0;
    end else if (t1Go) begin
      siCnt_ff <= scanIv_ff;
      siReq_ff <= 1'b0;
    end else if (!idle && !ctrl_ff.scanExt && siTick) begin
      siReq_ff <= siCnt_ff <= CNT_ONE;
      siCnt_ff <= siCnt_ff <= CNT_ONE ? scanIv_ff : siCnt_ff - CNT_ONE;
    end else begin
      siReq_ff <= 1'b0;
    end
  end

  // ==========================================
  // gate edge mode: active edges alternate shut and open
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gateShut_ff <= 1'b0;
    end else if (!ctrl_ff.gateEn || ctrl_ff.gateLvlMode) begin
      gateShut_ff <= 1'b0;
    end else if (selEdge(pinS2_ff, pinS3_ff, src_ff.gateSel, src_ff.gatePol)) begin
      gateShut_ff <= ~gateShut_ff;
    end
  end

  // ==========================================
  // scan in progress, sample interval and conversion count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scanBusy_ff <= 1'b0;
      convLeft_ff <= '0;
    end else if (scanGo) begin
      scanBusy_ff <= 1'b1;
      convLeft_ff <= convN_ff;
    end else if (idle || cmdStop) begin
      scanBusy_ff <= 1'b0;
    end else if (convGo) begin
      scanBusy_ff <= !lastConv;
      convLeft_ff <= convLeft_ff - CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sampCnt_ff <= '0;
    end else if (scanGo || !scanBusy_ff || convGo) begin
      sampCnt_ff <= sampIv_ff;
    end else begin
      sampCnt_ff <= sampCnt_ff - CNT_ONE;
    end
  end

  // ==========================================
  // output pulse timers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      t1Tmr_ff <= 3'h0;
      t2Tmr_ff <= 3'h0;
      scanTmr_ff <= 3'h0;
      convTmr_ff <= 3'h0;
    end else begin
      t1Tmr_ff <= tmrNext(t1Go && !cmdStop, t1Tmr_ff);
      t2Tmr_ff <= tmrNext(t2Go && !cmdStop, t2Tmr_ff);
      scanTmr_ff <= tmrNext(scanGo, scanTmr_ff);
      convTmr_ff <= tmrNext(convGo, convTmr_ff);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclkTmr_ff <= 5'h0;
      sclkOut_ff <= 1'b0;
    end else begin
      if (convGo) begin
        sclkTmr_ff <= SCLK_LD;
      end else if (sclkTmr_ff != 5'h0) begin
        sclkTmr_ff <= sclkTmr_ff - 5'h1;
      end
      sclkOut_ff <= (ctrl_ff.sclkEn && sclkTmr_ff != 5'h0
                     && sclkTmr_ff <= SCLK_WID) ^ ctrl_ff.sclkPol;
    end
  end

  // ==========================================
  // external strobe, active low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strbLeft_ff <= 5'h0;
      strbCnt_ff <= 9'h0;
      strbOut_ff <= 1'b1;
    end else begin
      if (cmdStrb && ctrl_ff.strbHw && strbLeft_ff == 5'h0) begin
        strbLeft_ff <= STRB_HALVES;
        strbCnt_ff <= ctrl_ff.strbFast ? STRB_FAST : STRB_SLOW;
      end else if (strbLeft_ff != 5'h0 && strbCnt_ff <= 9'h1) begin
        strbLeft_ff <= strbLeft_ff - 5'h1;
        strbCnt_ff <= ctrl_ff.strbFast ? STRB_FAST : STRB_SLOW;
      end else if (strbLeft_ff != 5'h0) begin
        strbCnt_ff <= strbCnt_ff - 9'h1;
      end
      // even half periods are the low phases of the burst
      // level bit set asserts the active-low strobe, so reset leaves it idle
      strbOut_ff <= ctrl_ff.strbHw ? !(strbLeft_ff != 5'h0 && !strbLeft_ff[0])
                    : !ctrl_ff.strbLevel;
    end
  end

  // ==========================================
  // function pin drivers, tri-stated from reset
  always_comb begin
    nxt_pinOut = '0;
    nxt_pinOut[ats_pkg::PIN_T1] = t1Tmr_ff != 3'h0;
    nxt_pinOut[ats_pkg::PIN_T2] = t2Tmr_ff != 3'h0;
    nxt_pinOut[ats_pkg::PIN_CONV] = convTmr_ff == 3'h0;
    nxt_pinOut[ats_pkg::PIN_SCAN] = ctrl_ff.scanOutLvl ? scanBusy_ff
                                    : scanTmr_ff != 3'h0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinOut_ff <= '0;
      pinOe_ff <= '0;
    end else begin
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= pinOeReg_ff;
    end
  end
endmodule

// ---- tb/ats_pin_model.sv ----
// pin-side source model: trigger edges, gate levels, external scan clock
// assumes the bench merges these levels with the design's own pin drivers
`timescale 1ns/10ps
module ats_pin_model (
  output logic [9:0] pinLvl,
  input wire logic ref_clk
);
  initial pinLvl = '0;
  // ==========
  // edges held four cycles, past the synchroniser
  task automatic pulse(input int p);
    @(posedge ref_clk);
    pinLvl[p] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pinLvl[p] <= 1'b0;
  endtask
  task automatic hold(input int p, input logic v);
    @(posedge ref_clk);
    pinLvl[p] <= v;
  endtask
  // 5 mhz, 100 ns phases: the design samples at 40 mhz
  task automatic siclk(input int p, input int n);
    repeat (2 * n) begin
      @(posedge ref_clk);
      pinLvl[p] <= ~pinLvl[p];
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule

// ---- tb/ats_sequencer_chk.sv ----
// port checker for the acquisition timing sequencer
// assumes a bind into ats_sequencer, one clock domain
`timescale 1ns/10ps
module ats_sequencer_chk #(
  parameter int NPINS = 10,
  parameter int CW = 24
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NPINS-1:0] functionPinIn,
  input wire logic [NPINS-1:0] functionPinOut,
  input wire logic [NPINS-1:0] functionPinOe,
  input wire logic scanClockOut,
  input wire logic externalStrobeOutN
);
  // ==========
  // shadow of mode bits, taken at the write edge
  logic wr;
  logic [4:0] mode_ff;
  logic [NPINS-1:0] oeW_ff;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= '0;
    end else if (wr && wb_sel_i[1] && wb_adr_i == ats_pkg::ADR_CTRL) begin
      mode_ff <= {wb_dat_i[13], wb_dat_i[11:8]};
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oeW_ff <= '0;
    end else if (wr && wb_adr_i == ats_pkg::ADR_PINOE) begin
      oeW_ff <= wb_dat_i[NPINS-1:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========
  // pulse shapes; conversions closer than the scan clock width not covered
  AST_T1_PULSE: assert property ($rose(functionPinOut[0]) |=> functionPinOut[0] ##1 !functionPinOut[0])
    else $error("start trigger pulse width wrong");
  AST_T2_PULSE: assert property ($rose(functionPinOut[1]) |=> functionPinOut[1] ##1 !functionPinOut[1])
    else $error("posttrigger pulse width wrong");
  AST_CONV_PULSE: assert property ($fell(functionPinOut[2]) |=> !functionPinOut[2] ##1 functionPinOut[2])
    else $error("conversion pulse width wrong");
  AST_SCAN_PULSE: assert property (!mode_ff[0] && $rose(functionPinOut[7]) |=>
    functionPinOut[7] ##1 !functionPinOut[7]) else $error("scan start pulse width wrong");
  AST_SCLK: assert property (mode_ff[1] && $fell(functionPinOut[2]) |-> ##2 (scanClockOut != mode_ff[2])
    ##15 (scanClockOut != mode_ff[2]) ##1 (scanClockOut == mode_ff[2])) else $error("scan clock timing wrong");
  AST_STRB_FAST: assert property (mode_ff[3] && mode_ff[4] && $fell(externalStrobeOutN) |->
    ##24 $rose(externalStrobeOutN)) else $error("fast strobe phase wrong");
  AST_STRB_SLOW: assert property (mode_ff[3] && !mode_ff[4] && $fell(externalStrobeOutN) |->
    ##200 $rose(externalStrobeOutN)) else $error("slow strobe phase wrong");
  AST_OE: assert property (wr && &wb_sel_i && wb_adr_i == ats_pkg::ADR_PINOE |->
    ##[2:3] functionPinOe == oeW_ff) else $error("pin enables not applied");
  cover property (mode_ff[3] && $fell(externalStrobeOutN));
  cover property ($rose(functionPinOut[1]));
  cover property (mode_ff[1] && $fell(functionPinOut[2]));
endmodule
bind ats_sequencer ats_sequencer_chk #(.NPINS(NPINS), .CW(CW)) chk (
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .functionPinIn(functionPinIn), .functionPinOut(functionPinOut),
  .functionPinOe(functionPinOe), .scanClockOut(scanClockOut), .externalStrobeOutN(externalStrobeOutN));

// ---- tb/tb_top.sv ----
// self-checking bench for the acquisition timing sequencer
// assumes package, design, pin model and checker compiled before it
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cs = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hf;
  logic ack;
  logic sclk;
  logic strbN;
  logic sPrev = 1'b1;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [9:0] pinOut;
  logic [9:0] pinOe;
  logic [9:0] pinLvl;
  logic [9:0] pPrev = '0;
  int miscompares = 0;
  int nChecks = 0;
  int t1n, t2n, scn, cvn, stn, k;
  always #12.5 ref_clk = ~ref_clk;
  ats_pin_model pm (.ref_clk(ref_clk), .pinLvl(pinLvl));
  ats_sequencer dut (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .functionPinIn((pinOe & pinOut) | (~pinOe & pinLvl)), .functionPinOut(pinOut),
    .functionPinOe(pinOe), .scanClockOut(sclk), .externalStrobeOutN(strbN));
  // ==========
  // event counters on the output pins
  always @(posedge ref_clk) begin
    pPrev <= pinOut;
    sPrev <= strbN;
    t1n += pinOut[0] & ~pPrev[0];
    t2n += pinOut[1] & ~pPrev[1];
    cvn += ~pinOut[2] & pPrev[2];
    scn += pinOut[7] & ~pPrev[7];
    stn += ~strbN & sPrev;
  end
  task automatic finalReport;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge ref_clk);
    cs <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (ack !== 1'b1 && i < 64);
    r = rdat;
    cs <= 1'b0;
    if (ack !== 1'b1) begin
      miscompares++;
      finalReport();
    end
  endtask
  task automatic cfg(input logic [31:0] c, input logic [31:0] s, input logic [31:0] p, input logic [31:0] t);
    wb(1'b1, ats_pkg::ADR_CTRL, c, q);
    wb(1'b1, ats_pkg::ADR_SRC, s, q);
    wb(1'b1, ats_pkg::ADR_PRE, p, q);
    wb(1'b1, ats_pkg::ADR_POST, t, q);
  endtask
  task automatic clr;
    {t1n, t2n, scn, cvn, stn} = '0;
  endtask
  task automatic stat;
    wb(1'b0, ats_pkg::ADR_STAT, 32'h0, q);
  endtask
  // ==========
  // scenarios
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    chk({pinOe, pinOut[1:0], sclk, strbN}, 32'h1);
    wb(1'b1, 8'h3c, 32'hffff_ffff, q);
    for (k = 0; k < 10; k++) begin
      wb(1'b0, (k < 9) ? 8'(k * 4) : 8'h3c, 32'h0, q);
      chk(q, (k > 2 && k < 8) ? 32'(ats_pkg::COUNT_RST) : 32'h0);
    end
    sel <= 4'h2;
    wb(1'b1, ats_pkg::ADR_SCANIV, 32'hffff_ffff, q);
    sel <= 4'hf;
    wb(1'b0, ats_pkg::ADR_SCANIV, 32'h0, q);
    chk(q, 32'h0000_ff01);
    wb(1'b1, ats_pkg::ADR_PINOE, 32'h87, q);
    wb(1'b1, ats_pkg::ADR_SCANIV, 32'h28, q);
    wb(1'b1, ats_pkg::ADR_SAMPIV, 32'h14, q);
    wb(1'b1, ats_pkg::ADR_CONVN, 32'h2, q);
    chk(pinOe, 32'h87);
    for (k = 0; k < 2; k++) begin
      cfg(k ? 32'h700 : 32'h200, 32'h3 | (k << 24), 32'h0, 32'h2);
      clr();
      pm.pulse(3);
      wt(800);
      stat();
      chk({q[1:0], t1n[5:0], t2n[7:0], scn[7:0], cvn[7:0]}, 32'h01000204);
    end
    cfg(32'h201, 32'h43, 32'h2, 32'h1);
    clr();
    wb(1'b1, ats_pkg::ADR_CMD, 32'h1, q);
    pm.pulse(4);
    wt(400);
    stat();
    chk({q[1:0], t1n[3:0], t2n[3:0]}, 32'h310);
    clr();
    pm.pulse(4);
    wt(400);
    stat();
    chk({q[1:0], t2n[3:0], scn[3:0]}, 32'h011);
    pm.hold(5, 1'b1);
    cfg(32'h68, 32'h0085_0003, 32'h0, 32'h2);
    wb(1'b1, ats_pkg::ADR_SCANIV, 32'h8, q);
    fork
      pm.siclk(8, 120);
    join_none
    clr();
    pm.pulse(3);
    wt(200);
    stat();
    chk({q[1:0], scn[3:0]}, 32'h20);
    pm.hold(5, 1'b0);
    wt(300);
    stat();
    chk({q[1:0], scn[3:0]}, 32'h2);
    cfg(32'h0, 32'h3, 32'h0, 32'h64);
    pm.pulse(3);
    wt(100);
    wb(1'b1, ats_pkg::ADR_CMD, 32'h2, q);
    clr();
    wt(200);
    stat();
    chk({q[1:0], scn[3:0]}, 32'h0);
    cfg(32'h6, 32'h6403, 32'h0, 32'h1);
    clr();
    pm.pulse(3);
    pm.pulse(6);
    pm.pulse(4);
    pm.pulse(6);
    pm.pulse(6);
    wt(20);
    stat();
    chk({q[1:0], scn[3:0], cvn[3:0]}, 32'h012);
    for (k = 0; k < 2; k++) begin
      wb(1'b1, ats_pkg::ADR_CTRL, k ? 32'h2800 : 32'h0800, q);
      clr();
      wb(1'b1, ats_pkg::ADR_CMD, 32'h4, q);
      wt(k ? 500 : 3300);
      chk(stn, ats_pkg::STRB_PULSES);
    end
    wb(1'b1, ats_pkg::ADR_CTRL, 32'h1000, q);
    wt(3);
    chk(strbN, 32'h0);
    wb(1'b1, ats_pkg::ADR_CTRL, 32'h0, q);
    wt(3);
    chk(strbN, 32'h1);
    finalReport();
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
endmodule
